// [speaker_path_pkg.sv]
// constants, field layout and gate states of the speaker processing chain
// assumes a 32-bit axi4-lite register bus and left-justified 32-bit pcm samples
package speaker_path_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LEVEL  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int B_GATE_EN     = 0;
  localparam int B_DITHER_EN   = 1;
  localparam int B_INVERT      = 2;
  localparam int B_DC_BLOCK    = 3;
  localparam int B_RAMP_UP     = 4;
  localparam int B_RAMP_DOWN   = 5;
  localparam int B_FEEDBACK    = 6;
  localparam int B_PROTECT     = 7;
  localparam int B_TONE_EN     = 8;
  localparam int B_BYPASS_EN   = 9;
  localparam int F_WSIZE_LO    = 10;
  localparam int F_BYPSRC_LO   = 12;
  localparam int F_FBCH_LO     = 15;
  localparam int F_PLAYCH_LO   = 18;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0080;

  // ----------------------------------------
  // level register fields
  // ----------------------------------------
  localparam int F_MUTE_LVL_LO = 0;
  localparam int F_REL_LVL_LO  = 8;
  localparam int F_VOL_LO      = 16;
  localparam int F_BOOST_LO    = 24;
  localparam logic [31:0] LEVEL_RESET = 32'h0000_0604;

  // ----------------------------------------
  // word size codes and audio lsb shifts
  // ----------------------------------------
  localparam logic [1:0] WSIZE_16      = 2'h0;
  localparam logic [1:0] WSIZE_24      = 2'h1;
  localparam logic [4:0] LSB_SHIFT_16  = 5'h10;
  localparam logic [4:0] LSB_SHIFT_24  = 5'h08;
  localparam logic [4:0] LSB_SHIFT_32  = 5'h00;

  // ----------------------------------------
  // gate, volume and gain counts
  // ----------------------------------------
  localparam logic [10:0] GATE_QUIET_SAMPLES = 11'h400;
  localparam logic [7:0]  VOL_MUTE_CODE      = 8'hff;
  localparam logic [7:0]  VOL_MAX_CODE       = 8'hb4;
  localparam logic [7:0]  BOOST_MAX          = 8'h0c;
  localparam logic [7:0]  STEPS_PER_HALVING  = 8'h0c;
  localparam logic [7:0]  PROTECT_STEPS      = 8'h24;
  localparam logic [7:0]  IDX_MAX            = 8'hc0;
  localparam logic [4:0]  DC_POLE_SHIFT      = 5'h0a;
  localparam logic [4:0]  GAIN_FRAC_BITS     = 5'h0f;

  // ----------------------------------------
  // bus answers and gate states
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GATE_OPEN  = 2'b00,
    GATE_COUNT = 2'b01,
    GATE_MUTED = 2'b11
  } gate_state_e;

endpackage : speaker_path_pkg

// [vol_step_rom.sv]
// half-decibel mantissa table for the volume and gain multiplier
// assumes the caller applies whole 6 db steps as shifts
`timescale 1ns/100ps
module vol_step_rom (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  frac,
  output logic      [16:0] mant
);

  // ----------------------------------------
  // table, q16, one entry per 0.5 db
  // ----------------------------------------
  // the 12th step is taken as an exact halving, 0.02 db off per octave
  logic [16:0] next_mant;

  always_comb
  begin
    case (frac)
      4'h0:    next_mant = 17'h10000;
      4'h1:    next_mant = 17'h0f1ae;
      4'h2:    next_mant = 17'h0e429;
      4'h3:    next_mant = 17'h0d766;
      4'h4:    next_mant = 17'h0cb59;
      4'h5:    next_mant = 17'h0bff9;
      4'h6:    next_mant = 17'h0b53c;
      4'h7:    next_mant = 17'h0ab19;
      4'h8:    next_mant = 17'h0a186;
      4'h9:    next_mant = 17'h0987d;
      4'ha:    next_mant = 17'h08ff5;
      4'hb:    next_mant = 17'h087e8;
      default: next_mant = 17'h08000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mant <= 17'h00000;
    else
      mant <= next_mant;
  end

endmodule : vol_step_rom

// [speaker_path_processing.sv]
// speaker path: source select, quiet gate, dither, invert, dc block, volume, boost
// assumes one sample clock domain and pcm_valid pulses one cycle per input channel word
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

// How it works
// - samples come from pcm input or tone, then process, filter, volume, gain.
// - quiet gate engages only while device active and gate enable is one.
// - clearing enable while muted keeps muting until normal release.
// - gate engages after more than 1024 consecutive quiet samples.
// - while muted, playback path is silent, sense data zero, low power flagged.
// - one loud sample releases gate before it reaches the output.
// - after release, sense data output resumes normally.
// - thresholds count low-order bits from the audio lsb that must toggle.
// - audio lsb position follows configured input word size.
// - dither enable adds one lsb peak-to-peak dither, else none.
// - polarity invert negates the playback samples.
// - dc block enable passes samples through a dc removal filter.
// - volume attenuates 0 to -90 db in 0.5 db steps, changeable live.
// - volume code 0xff mutes the path.
// - ramping off by default; ramp up and down enabled separately.
// - boost adds 0 to 6 db in 0.5 db steps; host keeps it still.
// - feedback enable copies the pre-dac samples to the serial output.
// - protect mode set at reset, applies -18 db, ignores volume and boost.
// - bypass select skips invert, volume and gain, taking the chosen input channel.
// - one dither enable serves both bypass and playback paths.
module speaker_path_processing (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        device_active,
  input  wire logic [31:0] pcm_sample,
  input  wire logic [2:0]  pcm_channel,
  input  wire logic        pcm_valid,
  input  wire logic [31:0] tone_sample,
  output logic      [31:0] dac_sample,
  output logic             dac_valid,
  output logic      [31:0] fb_sample,
  output logic      [2:0]  fb_channel,
  output logic             fb_valid,
  output logic             sense_zero,
  output logic             low_power
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    logic [31:0]                 ctrl;
    logic [31:0]                 level;
    speaker_path_pkg::gate_state_e gate;
    logic [10:0]                 quiet_count;
    logic [15:0]                 lfsr;
    logic [31:0]                 dc_x;
    logic [31:0]                 dc_y;
    logic [7:0]                  cur_idx;
    logic [7:0]                  target_idx;
    logic                        s1_valid;
    logic [31:0]                 s1_sample;
    logic [4:0]                  s1_shift;
    logic                        s1_mute;
    logic                        s1_bypass;
    logic [31:0]                 dac_sample;
    logic                        dac_valid;
    logic [31:0]                 fb_sample;
    logic                        fb_valid;
    logic                        sense_zero;
  } state_s;

  state_s      st;
  state_s      next_st;
  logic [3:0]  rom_frac;
  logic [16:0] mant;
  logic        take_play;
  logic        quiet;
  logic        loud;

  localparam logic signed [49:0] SAT_HI = 50'sh0_0000_7fff_ffff;
  localparam logic signed [49:0] SAT_LO = -50'sh0_0000_8000_0000;

  function automatic logic [31:0] sat_word(input logic signed [49:0] v);
    if (v > SAT_HI)
      return 32'h7fff_ffff;
    else if (v < SAT_LO)
      return 32'h8000_0000;
    else
      return v[31:0];
  endfunction : sat_word

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = data[8*b +: 8];
    return r;
  endfunction : merge

  vol_step_rom vol_step_rom_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .frac    (rom_frac),
    .mant    (mant)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [4:0]         lsb_shift;
    logic [31:0]        mag;
    logic [4:0]         mute_lvl;
    logic [4:0]         rel_lvl;
    logic [7:0]         vol;
    logic [7:0]         boost;
    logic               mute_target;
    logic               take_byp;
    logic signed [31:0] x;
    logic signed [33:0] acc;
    logic signed [49:0] prod;
    lsb_shift   = speaker_path_pkg::LSB_SHIFT_32;
    mag         = 32'h0;
    mute_lvl    = st.level[speaker_path_pkg::F_MUTE_LVL_LO +: 5];
    rel_lvl     = st.level[speaker_path_pkg::F_REL_LVL_LO +: 5];
    vol         = st.level[speaker_path_pkg::F_VOL_LO +: 8];
    boost       = {4'h0, st.level[speaker_path_pkg::F_BOOST_LO +: 4]};
    mute_target = 1'b0;
    take_byp    = 1'b0;
    x           = 32'sh0;
    acc         = 34'sh0;
    prod        = 50'sh0;
    next_st     = st;

    // bus slave: write ready pulses once both address and data stand, read ready once the address stands
    next_st.awready = 1'b0;
    next_st.wready  = 1'b0;
    next_st.arready = 1'b0;
    if (!st.bvalid && !st.awready && s_axi_awvalid && s_axi_wvalid)
    begin
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end
    if (st.awready && s_axi_awvalid && s_axi_wvalid)
    begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = speaker_path_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        speaker_path_pkg::ADDR_CTRL:   next_st.ctrl  = merge(st.ctrl, s_axi_wdata, s_axi_wstrb);
        speaker_path_pkg::ADDR_LEVEL:  next_st.level = merge(st.level, s_axi_wdata, s_axi_wstrb);
        speaker_path_pkg::ADDR_STATUS: next_st.bresp = speaker_path_pkg::RESP_OKAY;
        default:                       next_st.bresp = speaker_path_pkg::RESP_SLVERR;
      endcase
    end
    else if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    if (!st.rvalid && !st.arready && s_axi_arvalid)
      next_st.arready = 1'b1;
    if (st.arready && s_axi_arvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = speaker_path_pkg::RESP_OKAY;
      case (s_axi_araddr)
        speaker_path_pkg::ADDR_CTRL:   next_st.rdata = st.ctrl;
        speaker_path_pkg::ADDR_LEVEL:  next_st.rdata = st.level;
        speaker_path_pkg::ADDR_STATUS: next_st.rdata = {5'h0, st.quiet_count, st.cur_idx, 5'h0,
                                                        st.cur_idx != st.target_idx, st.gate};
        default:
        begin
          next_st.rdata = 32'h0;
          next_st.rresp = speaker_path_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;

    // audio lsb position from word size
    case (st.ctrl[speaker_path_pkg::F_WSIZE_LO +: 2])
      speaker_path_pkg::WSIZE_16: lsb_shift = speaker_path_pkg::LSB_SHIFT_16;
      speaker_path_pkg::WSIZE_24: lsb_shift = speaker_path_pkg::LSB_SHIFT_24;
      default:                    lsb_shift = speaker_path_pkg::LSB_SHIFT_32;
    endcase

    take_byp  = pcm_valid && st.ctrl[speaker_path_pkg::B_BYPASS_EN]
                && pcm_channel == st.ctrl[speaker_path_pkg::F_BYPSRC_LO +: 3];
    take_play = pcm_valid && !st.ctrl[speaker_path_pkg::B_BYPASS_EN]
                && pcm_channel == st.ctrl[speaker_path_pkg::F_PLAYCH_LO +: 3];

    // amplitude in audio lsbs; level n means bits above the n lowest are active
    mag   = pcm_sample[31] ? 32'(-pcm_sample) : pcm_sample;
    mag   = mag >> lsb_shift;
    quiet = (mag >> mute_lvl) == 32'h0;
    loud  = (mag >> rel_lvl) != 32'h0;

    // quiet gate
    if (take_play)
    begin
      case (st.gate)
        speaker_path_pkg::GATE_MUTED:
        begin
          if (loud || !device_active)
          begin
            next_st.gate        = speaker_path_pkg::GATE_OPEN;
            next_st.quiet_count = 11'h0;
          end
        end
        speaker_path_pkg::GATE_OPEN, speaker_path_pkg::GATE_COUNT:
        begin
          if (!device_active || !st.ctrl[speaker_path_pkg::B_GATE_EN] || !quiet)
          begin
            next_st.gate        = speaker_path_pkg::GATE_OPEN;
            next_st.quiet_count = 11'h0;
          end
          else if (st.quiet_count == speaker_path_pkg::GATE_QUIET_SAMPLES)
          begin
            next_st.gate        = speaker_path_pkg::GATE_MUTED;
            next_st.quiet_count = 11'h0;
          end
          else
          begin
            next_st.gate        = speaker_path_pkg::GATE_COUNT;
            next_st.quiet_count = st.quiet_count + 11'h1;
          end
        end
        default: next_st.gate = speaker_path_pkg::GATE_OPEN;
      endcase
    end

    // stage one: source, dither, invert, dc block
    next_st.s1_valid  = take_play || take_byp;
    next_st.s1_bypass = take_byp;
    if (take_play || take_byp)
    begin
      next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[14] ^ st.lfsr[12] ^ st.lfsr[3]};
      x = (take_play && st.ctrl[speaker_path_pkg::B_TONE_EN]) ? tone_sample : pcm_sample;
      if (st.ctrl[speaker_path_pkg::B_DITHER_EN] && st.lfsr[0])
        x = sat_word(50'(x) + 50'(32'sh1 <<< lsb_shift));
      if (take_play && st.ctrl[speaker_path_pkg::B_INVERT])
        x = sat_word(-50'(x));
      if (st.ctrl[speaker_path_pkg::B_DC_BLOCK])
      begin
        acc          = 34'(x) - 34'($signed(st.dc_x)) + 34'($signed(st.dc_y))
                       - 34'($signed(st.dc_y) >>> speaker_path_pkg::DC_POLE_SHIFT);
        next_st.dc_x = x;
        next_st.dc_y = sat_word(50'(acc));
        x            = sat_word(50'(acc));
      end
      else
      begin
        next_st.dc_x = x;
        next_st.dc_y = 32'h0;
      end
      next_st.s1_sample = x;
    end

    // volume target: 12 steps above index zero make up the boost range
    if (st.ctrl[speaker_path_pkg::B_PROTECT])
      next_st.target_idx = speaker_path_pkg::STEPS_PER_HALVING + speaker_path_pkg::PROTECT_STEPS;
    else if (vol == speaker_path_pkg::VOL_MUTE_CODE || !device_active)
    begin
      next_st.target_idx = speaker_path_pkg::IDX_MAX;
      mute_target        = 1'b1;
    end
    else
      next_st.target_idx = (vol > speaker_path_pkg::VOL_MAX_CODE ? speaker_path_pkg::VOL_MAX_CODE : vol)
                           + speaker_path_pkg::STEPS_PER_HALVING
                           - (boost > speaker_path_pkg::BOOST_MAX ? speaker_path_pkg::BOOST_MAX : boost);

    // ramps move one step per sample, otherwise the volume jumps
    if (take_play)
    begin
      if (st.cur_idx < next_st.target_idx)
        next_st.cur_idx = st.ctrl[speaker_path_pkg::B_RAMP_DOWN] ? st.cur_idx + 8'h1 : next_st.target_idx;
      else if (st.cur_idx > next_st.target_idx)
        next_st.cur_idx = st.ctrl[speaker_path_pkg::B_RAMP_UP] ? st.cur_idx - 8'h1 : next_st.target_idx;
      next_st.s1_shift = 5'(next_st.cur_idx / speaker_path_pkg::STEPS_PER_HALVING);
      next_st.s1_mute  = next_st.gate == speaker_path_pkg::GATE_MUTED
                         || (mute_target && next_st.cur_idx == speaker_path_pkg::IDX_MAX);
    end
    rom_frac = 4'(next_st.cur_idx % speaker_path_pkg::STEPS_PER_HALVING);

    // stage two: multiply, feedback tap
    next_st.dac_valid = st.s1_valid;
    next_st.fb_valid  = st.s1_valid && st.ctrl[speaker_path_pkg::B_FEEDBACK];
    if (st.s1_valid)
    begin
      prod = 50'($signed(st.s1_sample)) * 50'($signed({1'b0, mant}));
      prod = prod >>> (speaker_path_pkg::GAIN_FRAC_BITS + st.s1_shift);
      if (st.s1_bypass)
        next_st.dac_sample = st.s1_sample;
      else if (st.s1_mute)
        next_st.dac_sample = 32'h0;
      else
        next_st.dac_sample = sat_word(prod);
      next_st.fb_sample = next_st.dac_sample;
    end
    next_st.sense_zero = st.gate == speaker_path_pkg::GATE_MUTED;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st             <= '0;
      st.ctrl        <= speaker_path_pkg::CTRL_RESET;
      st.level       <= speaker_path_pkg::LEVEL_RESET;
      st.gate        <= speaker_path_pkg::GATE_OPEN;
      st.lfsr        <= 16'h0001;
      st.cur_idx     <= speaker_path_pkg::IDX_MAX;
      st.target_idx  <= speaker_path_pkg::IDX_MAX;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = st.rdata;
  assign dac_sample    = st.dac_sample;
  assign dac_valid     = st.dac_valid;
  assign fb_sample     = st.fb_sample;
  assign fb_channel    = st.ctrl[speaker_path_pkg::F_FBCH_LO +: 3];
  assign fb_valid      = st.fb_valid;
  assign sense_zero    = st.sense_zero;
  assign low_power     = st.sense_zero;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_gate_engage: assert property (take_play && device_active && st.ctrl[0] && quiet
      && st.gate != speaker_path_pkg::GATE_MUTED && st.quiet_count == 11'h400
      |=> st.gate == speaker_path_pkg::GATE_MUTED ##1 sense_zero)
    else $error("gate did not engage after quiet run");
  a_gate_early: assert property (st.gate != speaker_path_pkg::GATE_MUTED && st.quiet_count < 11'h400
      |=> st.gate != speaker_path_pkg::GATE_MUTED)
    else $error("gate engaged too early");
  a_gate_release: assert property (take_play && loud && st.gate == speaker_path_pkg::GATE_MUTED
      |=> !st.s1_mute || st.cur_idx == speaker_path_pkg::IDX_MAX ##1 !sense_zero)
    else $error("loud sample did not release gate");
  a_gate_hold: assert property (take_play && !loud && device_active
      && st.gate == speaker_path_pkg::GATE_MUTED |=> st.gate == speaker_path_pkg::GATE_MUTED)
    else $error("gate left mute without release");
  a_gate_off: assert property (!st.ctrl[0] && st.gate != speaker_path_pkg::GATE_MUTED
      |=> st.gate != speaker_path_pkg::GATE_MUTED)
    else $error("gate muted while disabled");
  a_sense_zero: assert property (st.gate == speaker_path_pkg::GATE_MUTED |=> sense_zero && low_power)
    else $error("sense data not zeroed while gated");
  a_vol_mute: assert property (take_play && !st.ctrl[7] && !st.ctrl[5]
      && st.level[23:16] == 8'hff |=> ##1 dac_valid && dac_sample == 32'h0)
    else $error("mute code did not silence output");
  a_protect_reset: assert property (!$past(aresetn) |-> st.ctrl[7])
    else $error("protect mode not set after reset");
  a_feedback_tap: assert property (fb_valid |-> dac_valid && fb_sample == dac_sample)
    else $error("feedback tap differs from dac data");
  a_bus_answer: assert property (st.awready && s_axi_awvalid && s_axi_wvalid |=> s_axi_bvalid)
    else $error("write not answered");

  c_gate_engage: cover property (st.gate == speaker_path_pkg::GATE_COUNT ##1 st.gate == speaker_path_pkg::GATE_MUTED);
  c_gate_release: cover property (st.gate == speaker_path_pkg::GATE_MUTED ##1 st.gate == speaker_path_pkg::GATE_OPEN);
  c_ramp_step: cover property (take_play && st.cur_idx != st.target_idx ##1 st.cur_idx != st.target_idx);
  c_reg_write: cover property (s_axi_bvalid && s_axi_bready);

endmodule : speaker_path_processing

// [pcm_host_model.sv]
// pcm link source standing in for the host audio processor
// assumes the bench calls send only after the previous word has left
`timescale 1ns/100ps
module pcm_host_model (
  input  wire logic        aclk,
  output logic      [31:0] pcm_sample,
  output logic      [2:0]  pcm_channel,
  output logic             pcm_valid
);
  initial
  begin
    pcm_sample  = 32'h0;
    pcm_channel = 3'h0;
    pcm_valid   = 1'b0;
  end
  // released lines show the inverse, so a stale word never looks valid
  task automatic send(input logic [31:0] x, input logic [2:0] c);
    @(posedge aclk);
    pcm_sample  <= x;
    pcm_channel <= c;
    pcm_valid   <= 1'b1;
    @(posedge aclk);
    pcm_valid   <= 1'b0;
    pcm_sample  <= ~x;
    pcm_channel <= ~c;
  endtask : send
endmodule : pcm_host_model

// [speaker_path_processing_tb.sv]
// self-checking bench for the speaker path
// assumes the host model feeds pcm words and axi tasks reach the registers
`timescale 1ns/100ps
module speaker_path_processing_tb;
  localparam logic [7:0] CT = speaker_path_pkg::ADDR_CTRL;
  localparam logic [7:0] LV = speaker_path_pkg::ADDR_LEVEL;
  typedef struct {logic [31:0] c; logic [31:0] l; logic [2:0] h; real g;} row_s;
  logic        aclk, aresetn, awv, wv, bvalid, bready, awrdy, wrdy, arv, arrdy, rvalid, rready;
  logic        pv, dv, fbv, sz, lp, act;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, pcm, tone, dac, fbs, y, d;
  logic [1:0]  rresp, r, br, b;
  logic [2:0]  ch, fbch;
  int          n_errors, n_tests, k;
  row_s        rows [12];
  speaker_path_processing speaker_path_processing_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .device_active(act),
    .pcm_sample(pcm), .pcm_channel(ch), .pcm_valid(pv), .tone_sample(tone), .dac_sample(dac),
    .dac_valid(dv), .fb_sample(fbs), .fb_channel(fbch), .fb_valid(fbv), .sense_zero(sz), .low_power(lp));
  pcm_host_model pcm_host_model_inst (.aclk(aclk), .pcm_sample(pcm), .pcm_channel(ch), .pcm_valid(pv));
  // ----------------------------------------
  // bus, stream and check tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ta;
    bit td;
    ta = 1'b0;
    td = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata  <= v;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    // each channel is released at its own ready
    do
    begin
      @(posedge aclk);
      if (awrdy === 1'b1)
        awv <= 1'b0;
      if (wrdy === 1'b1)
        wv <= 1'b0;
      ta = ta || awrdy === 1'b1;
      td = td || wrdy === 1'b1;
    end
    while (!(ta && td));
    do @(posedge aclk); while (bvalid !== 1'b1);
    b = br;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arrdy !== 1'b1);
    arv    <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // waits on dac_valid; a word that is never taken is cut short by the watchdog
  task automatic play(input logic [31:0] x);
    pcm_host_model_inst.send(x, 3'h0);
    do @(posedge aclk); while (dv !== 1'b1);
    y  = dac;
  endtask : play
  task automatic quiet(input int n);
    repeat (n) play(32'h0001_0000);
  endtask : quiet
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // tolerance covers the 0.02 db per halving error of the gain table
  function automatic bit near(input logic [31:0] v, input real e);
    real q;
    q = $itor($signed(v)) - e;
    return !$isunknown(v) && (q < 0 ? -q : q) <= 4.0 + 0.05 * (e < 0 ? -e : e);
  endfunction : near
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial
  begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    complete_run;
  end
  initial
  begin
    {aresetn, awv, wv, bready, arv, rready, awaddr, araddr, wdata, tone} = '0;
    act = 1'b1;
    rows = '{'{32'h0, 32'h0000_0604, 3'h0, 1.0},
             '{32'h0, 32'h000c_0604, 3'h0, 0.501187},
             '{32'h0, 32'h00b4_0604, 3'h0, 3.16228e-5},
             '{32'h0, 32'h00ff_0604, 3'h0, 0.0},
             '{32'h0, 32'h0c00_0604, 3'h0, 1.995262},
             '{32'h80, 32'h0cff_0604, 3'h0, 0.125893},
             '{32'h4, 32'h0000_0604, 3'h0, -1.0},
             '{32'h100, 32'h0000_0604, 3'h0, 1.0},
             '{32'h3200, 32'h00ff_0604, 3'h3, 1.0},
             '{32'h28040, 32'h0000_0604, 3'h0, 1.0},
             '{32'h8, 32'h0000_0604, 3'h0, 0.0},
             '{32'h20, 32'h00ff_0604, 3'h0, 0.891251}};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CT);
    chk(d === speaker_path_pkg::CTRL_RESET, "ctrl reset value");
    rd(8'h0c);
    chk(r === speaker_path_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
    wr(8'h0c, 32'h0);
    chk(b === speaker_path_pkg::RESP_SLVERR, "unmapped write");
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(CT, rows[i].c);
      wr(LV, rows[i].l);
      tone <= rows[i].c[8] ? 32'h1000_0000 : 32'h0;
      // second word sees the new volume, as ramping is off; row 11 has ramp down on and is two steps into its ramp
      repeat (2) pcm_host_model_inst.send(rows[i].c[8] ? 32'h7000_0000 : 32'h1000_0000, rows[i].h);
      do @(posedge aclk); while (dv !== 1'b1);
      chk(near(dac, rows[i].g * 268435456.0), "row output");
      if (rows[i].c[6])
        chk(fbv === 1'b1 && fbs === dac && fbch === 3'h5, "feedback copy");
      else
        chk(fbv === 1'b0, "feedback while off");
      $display("row %0d done", i);
    end
    wr(LV, 32'h0000_0604);
    wr(CT, 32'h0000_0401);
    quiet(1025);
    chk(sz === 1'b0, "mute with 24 bit words");
    wr(CT, 32'h0000_0001);
    quiet(1024);
    chk(sz === 1'b0, "early mute");
    quiet(1);
    chk(y === 32'h0 && sz === 1'b1 && lp === 1'b1, "gate mute");
    play(32'h0100_0000);
    chk(near(y, 16777216.0), "release sample");
    chk(sz === 1'b0 && lp === 1'b0, "sense resumed");
    quiet(1025);
    wr(CT, 32'h0);
    play(32'h0001_0000);
    chk(sz === 1'b1 && y === 32'h0, "mute held");
    play(32'h0100_0000);
    chk(sz === 1'b0 && near(y, 16777216.0), "late release");
    // 17 words always hold both dither values of the 16-bit lfsr sequence
    wr(CT, 32'h0000_0002);
    k = 0;
    repeat (17)
    begin
      play(32'h1000_0000);
      chk(y === 32'h1000_0000 || y === 32'h1001_0000, "dither size");
      k += int'(y === 32'h1001_0000);
    end
    chk(k > 0 && k < 17, "dither missing");
    wr(CT, 32'h0000_0001);
    act <= 1'b0;
    quiet(1025);
    chk(sz === 1'b0 && y === 32'h0, "gate while inactive");
    $display("gate test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CT);
    chk(d === speaker_path_pkg::CTRL_RESET, "ctrl after second reset");
    $display("second reset test done");
    complete_run;
  end
endmodule : speaker_path_processing_tb
